// [rtl/ulmc_pkg.sv]
// Package for the dual-channel line and modem control block.
// Assumes an APB master on the same clock and a 32-bit data path.
package ulmc_pkg;
    localparam int NUM_CH = 2;
    localparam logic [7:0] ADDR_W = 8'h08;
    // Register byte addresses; channel B sits one block above channel A.
    localparam logic [7:0] OFF_LFC = 8'h00;
    localparam logic [7:0] OFF_MLC = 8'h04;
    localparam logic [7:0] OFF_EFG = 8'h08;
    localparam logic [7:0] OFF_PFS = 8'h0C;
    localparam logic [7:0] OFF_PLR = 8'h10;
    localparam logic [7:0] OFF_STS = 8'h14;
    localparam logic [7:0] CH_STRIDE = 8'h20;
    localparam logic [7:0] CH_MASK = 8'h1F;
    // Line format fields.
    localparam int LFC_DLAB = 7;
    localparam int LFC_BRK = 6;
    localparam int LFC_FORCE = 5;
    localparam int LFC_EVEN = 4;
    localparam int LFC_PEN = 3;
    localparam int LFC_STOP = 2;
    // Modem line control fields.
    localparam int MLC_PRESC = 7;
    localparam int MLC_IR = 6;
    localparam int MLC_XANY = 5;
    localparam int MLC_LOOP = 4;
    localparam int MLC_TRIG = 2;
    localparam int MLC_RTS = 1;
    localparam int MLC_DTR = 0;
    localparam logic [7:0] MLC_GATED = 8'hE4;
    localparam logic [7:0] MLC_WMASK = 8'hF7;
    localparam int EFG_EN = 4;
    localparam int PFS_DTR_SEL = 1;
    localparam int PFS_AUTO_RTS = 2;
    localparam int PIN_FIVE = 5;
    localparam int PIN_ONE = 1;
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [1:0] PRESC_LAST = 2'h3;
    typedef struct packed {
        logic [3:0] data_bits;
        logic parity_en;
        logic parity_val_fixed;
        logic parity_forced;
        logic parity_even;
        logic [1:0] stop_halves;
        logic break_tx;
        logic divisor_access;
    } ulmc_fmt_t;
    typedef struct packed {
        logic baud_tick_en;
        logic infrared;
        logic resume_any;
        logic loopback;
        logic trig_access;
    } ulmc_mode_t;
endpackage

// [rtl/ulmc_top.sv]
// Line format and modem control registers for both serial channels.
// Assumes an APB master on clk; serial pins come from another domain.
//
// Contract
// [RULE1] Format bit 7 selects divisor access.
// [RULE2] Format bit 6 holds transmit low.
// [RULE3] Format bit 3 enables parity both ways.
// [RULE4] Parity disabled ignores bits five, four.
// [RULE5] Bit 4 picks odd or even.
// [RULE6] Bit 5 forces parity to inverse bit4.
// [RULE7] Bit 2 gives one, 1.5, two stops.
// [RULE8] Bits 1:0 give five to eight bits.
// [RULE9] Control bit 7 divides clock by four.
// [RULE10] Control bit 6 selects infrared mode.
// [RULE11] Control bit 5 enables resume on any.
// [RULE12] Control bit 4 loops transmit to receive.
// [RULE13] Loopback routes control bits into status.
// [RULE14] Control bit 2 opens trigger registers.
// [RULE15] Control bit 1 drives active-low request; code drives it from synchronised auto_rts_level instead when PFS bit 2 is set.
// [RULE16] Control bit 0 drives selected terminal pin; code drives both pins five and one when PFS bit 1 is set, else neither.
// [RULE17] Pin level writes ignored on terminal pin.
// [RULE18] Gated control bits need enhanced gate.
// [RULE19] Each channel keeps independent control copies.
`timescale 1ns/100ps
`default_nettype none
module ulmc_top #(
    parameter int NCH = ulmc_pkg::NUM_CH
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [NCH-1:0] tx_serial_in,
    input wire logic [NCH-1:0] rx_pin,
    input wire logic [NCH-1:0] auto_rts_level,
    output logic [NCH-1:0] tx_pin,
    output logic [NCH-1:0] rx_serial_out,
    output logic [NCH-1:0] rts_n,
    output logic [NCH-1:0] pin_five_out,
    output logic [NCH-1:0] pin_one_out,
    output logic [NCH-1:0] loop_status_four,
    output logic [NCH-1:0] loop_status_five,
    output ulmc_pkg::ulmc_fmt_t [NCH-1:0] fmt,
    output ulmc_pkg::ulmc_mode_t [NCH-1:0] mode
);
    logic [7:0] lfc_r [NCH];
    logic [7:0] mlc_r [NCH];
    logic [7:0] efg_r [NCH];
    logic [7:0] pfs_r [NCH];
    logic [7:0] plr_r [NCH];
    logic [1:0] presc_r [NCH];
    logic [NCH-1:0] rx_meta_r;
    logic [NCH-1:0] rx_sync_r;
    logic [NCH-1:0] arts_meta_r;
    logic [NCH-1:0] arts_sync_r;
    logic [31:0] prdata_nxt;
    logic wr_en;
    logic [7:0] reg_off;
    int unsigned ch_sel;
    logic ch_ok;

    // Word length code to bit count; shared by transmit and receive sides.
    function automatic logic [3:0] word_bits(input logic [1:0] code);
        word_bits = 4'h5 + {2'b00, code};
    endfunction

    // Writes land on the access phase only, so every access has no wait.
    assign pready = 1'b1;
    assign wr_en = psel && penable && pwrite;
    assign reg_off = paddr & ulmc_pkg::CH_MASK;
    assign ch_sel = 32'(paddr / ulmc_pkg::CH_STRIDE);
    assign ch_ok = ch_sel < NCH && (reg_off <= ulmc_pkg::OFF_STS) && (paddr[1:0] == 2'b00);
    assign pslverr = psel && penable && !ch_ok;

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            rx_meta_r <= '0;
            rx_sync_r <= '0;
            arts_meta_r <= '0;
            arts_sync_r <= '0;
        end else begin
            rx_meta_r <= rx_pin;
            rx_sync_r <= rx_meta_r;
            arts_meta_r <= auto_rts_level;
            arts_sync_r <= arts_meta_r;
        end
    end

    for (genvar c = 0; c < NCH; c++) begin : g_ch
        logic hit;
        logic [7:0] wbyte;
        logic dtr_on_five;
        logic dtr_on_one;
        assign hit = wr_en && ch_ok && (ch_sel == c);
        assign wbyte = pwdata[7:0];
        assign dtr_on_five = pfs_r[c][ulmc_pkg::PFS_DTR_SEL];
        assign dtr_on_one = pfs_r[c][ulmc_pkg::PFS_DTR_SEL];

        // [RULE19] Per-channel format copy.
        always_ff @(posedge clk or posedge sys_rst) begin
            if (sys_rst) begin
                lfc_r[c] <= ulmc_pkg::RST_BYTE;
            end else if (hit && reg_off == ulmc_pkg::OFF_LFC) begin
                lfc_r[c] <= wbyte;
            end
        end

        // [RULE18] Enhanced gate masks writes.
        always_ff @(posedge clk or posedge sys_rst) begin
            if (sys_rst) begin
                mlc_r[c] <= ulmc_pkg::RST_BYTE;
            end else if (hit && reg_off == ulmc_pkg::OFF_MLC) begin
                if (efg_r[c][ulmc_pkg::EFG_EN]) begin
                    mlc_r[c] <= wbyte & ulmc_pkg::MLC_WMASK;
                end else begin
                    mlc_r[c] <= ((wbyte & ulmc_pkg::MLC_WMASK) & ~ulmc_pkg::MLC_GATED)
                        | (mlc_r[c] & ulmc_pkg::MLC_GATED);
                end
            end
        end

        always_ff @(posedge clk or posedge sys_rst) begin
            if (sys_rst) begin
                efg_r[c] <= ulmc_pkg::RST_BYTE;
                pfs_r[c] <= ulmc_pkg::RST_BYTE;
                plr_r[c] <= ulmc_pkg::RST_BYTE;
            end else if (hit) begin
                if (reg_off == ulmc_pkg::OFF_EFG) begin
                    efg_r[c] <= wbyte;
                end
                if (reg_off == ulmc_pkg::OFF_PFS) begin
                    pfs_r[c] <= wbyte;
                end
                if (reg_off == ulmc_pkg::OFF_PLR) begin
                    plr_r[c] <= wbyte;
                end
            end
        end

        // [RULE9] Divide by four prescaler.
        always_ff @(posedge clk or posedge sys_rst) begin
            if (sys_rst) begin
                presc_r[c] <= 2'h0;
            end else begin
                presc_r[c] <= presc_r[c] + 2'h1;
            end
        end

        always_comb begin
            // [RULE8] Word length decode.
            fmt[c].data_bits = word_bits(lfc_r[c][1:0]);
            // [RULE3] Parity enable.
            fmt[c].parity_en = lfc_r[c][ulmc_pkg::LFC_PEN];
            // [RULE4] Parity kinds zeroed when off.
            fmt[c].parity_forced = lfc_r[c][ulmc_pkg::LFC_PEN] && lfc_r[c][ulmc_pkg::LFC_FORCE];
            // [RULE5] Odd or even.
            fmt[c].parity_even = lfc_r[c][ulmc_pkg::LFC_PEN] && lfc_r[c][ulmc_pkg::LFC_EVEN];
            // [RULE6] Forced value is inverse.
            fmt[c].parity_val_fixed = fmt[c].parity_forced && !lfc_r[c][ulmc_pkg::LFC_EVEN];
            // [RULE7] Stop length in half bits.
            if (!lfc_r[c][ulmc_pkg::LFC_STOP]) begin
                fmt[c].stop_halves = 2'd2;
            end else if (lfc_r[c][1:0] == 2'b00) begin
                fmt[c].stop_halves = 2'd3;
            end else begin
                fmt[c].stop_halves = 2'd0;
            end
            fmt[c].break_tx = lfc_r[c][ulmc_pkg::LFC_BRK];
            // [RULE1] Divisor latch select.
            fmt[c].divisor_access = lfc_r[c][ulmc_pkg::LFC_DLAB];
            // Presence of the whole tick vs quarter rate.
            mode[c].baud_tick_en = !mlc_r[c][ulmc_pkg::MLC_PRESC] || presc_r[c] == ulmc_pkg::PRESC_LAST;
            // [RULE10] Infrared select.
            mode[c].infrared = mlc_r[c][ulmc_pkg::MLC_IR];
            // [RULE11] Resume on any.
            mode[c].resume_any = mlc_r[c][ulmc_pkg::MLC_XANY];
            mode[c].loopback = mlc_r[c][ulmc_pkg::MLC_LOOP];
            // [RULE14] Trigger register access.
            mode[c].trig_access = mlc_r[c][ulmc_pkg::MLC_TRIG];
        end

        always_comb begin
            // [RULE2] Break forces line low; loopback keeps pin idle high.
            if (lfc_r[c][ulmc_pkg::LFC_BRK]) begin
                tx_pin[c] = 1'b0;
            end else if (mlc_r[c][ulmc_pkg::MLC_LOOP]) begin
                tx_pin[c] = 1'b1;
            end else begin
                tx_pin[c] = tx_serial_in[c];
            end
            // [RULE12] Internal loop to receiver.
            rx_serial_out[c] = mlc_r[c][ulmc_pkg::MLC_LOOP] ? (tx_serial_in[c] &&
                !lfc_r[c][ulmc_pkg::LFC_BRK]) : rx_sync_r[c];
            // [RULE15] Request output, active low.
            if (pfs_r[c][ulmc_pkg::PFS_AUTO_RTS]) begin
                rts_n[c] = arts_sync_r[c];
            end else begin
                rts_n[c] = !mlc_r[c][ulmc_pkg::MLC_RTS];
            end
            // [RULE16] Terminal-ready drive.
            // [RULE17] Pin level ignored.
            pin_five_out[c] = dtr_on_five ? !mlc_r[c][ulmc_pkg::MLC_DTR] : plr_r[c][ulmc_pkg::PIN_FIVE];
            pin_one_out[c] = dtr_on_one ? !mlc_r[c][ulmc_pkg::MLC_DTR] : plr_r[c][ulmc_pkg::PIN_ONE];
            // [RULE13] Loopback status routing.
            loop_status_four[c] = mlc_r[c][ulmc_pkg::MLC_LOOP] && mlc_r[c][ulmc_pkg::MLC_RTS];
            loop_status_five[c] = mlc_r[c][ulmc_pkg::MLC_LOOP] && mlc_r[c][ulmc_pkg::MLC_DTR];
        end
    end

    // Read data is registered, so it is valid in the access phase after setup.
    always_comb begin
        prdata_nxt = '0;
        if (ch_ok) begin
            case (reg_off)
                ulmc_pkg::OFF_LFC: prdata_nxt = {24'h0000_00, lfc_r[ch_sel]};
                ulmc_pkg::OFF_MLC: prdata_nxt = {24'h0000_00, mlc_r[ch_sel]};
                ulmc_pkg::OFF_EFG: prdata_nxt = {24'h0000_00, efg_r[ch_sel]};
                ulmc_pkg::OFF_PFS: prdata_nxt = {24'h0000_00, pfs_r[ch_sel]};
                ulmc_pkg::OFF_PLR: prdata_nxt = {24'h0000_00, plr_r[ch_sel]};
                ulmc_pkg::OFF_STS: prdata_nxt = {26'h000_0000, loop_status_five[ch_sel],
                    loop_status_four[ch_sel], 2'b00, rts_n[ch_sel], tx_pin[ch_sel]};
                default: prdata_nxt = '0;
            endcase
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            prdata <= '0;
        end else if (psel && !penable) begin
            prdata <= prdata_nxt;
        end
    end
endmodule
`default_nettype wire

// [verification/ulmc_top_sva.sv]
// Checker for the line and modem control block, channel zero.
// Assumes it is bound into ulmc_top and sees only its ports.
`timescale 1ns/100ps
`default_nettype none
module ulmc_top_chk #(
    parameter int NCH = 2
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [NCH-1:0] tx_serial_in,
    input wire logic [NCH-1:0] tx_pin,
    input wire logic [NCH-1:0] rx_serial_out,
    input wire logic [NCH-1:0] loop_status_four,
    input wire ulmc_pkg::ulmc_fmt_t [NCH-1:0] fmt,
    input wire ulmc_pkg::ulmc_mode_t [NCH-1:0] mode
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (sys_rst);
    property p_div;
        psel && penable && pwrite && paddr == 8'h00 |=> fmt[0].divisor_access == $past(pwdata[7]);
    endproperty
    a_div: assert property (p_div) else $error("divisor access");
    property p_brk;
        fmt[0].break_tx |-> !tx_pin[0];
    endproperty
    a_brk: assert property (p_brk) else $error("break");
    property p_force;
        fmt[0].parity_en && fmt[0].parity_forced |-> fmt[0].parity_val_fixed != fmt[0].parity_even;
    endproperty
    a_force: assert property (p_force) else $error("forced parity");
    property p_stop;
        fmt[0].stop_halves != 2'h2 |-> fmt[0].stop_halves == ((fmt[0].data_bits == 4'h5) ? 2'h3 : 2'h0);
    endproperty
    a_stop: assert property (p_stop) else $error("stop length");
    property p_len;
        fmt[0].data_bits >= 4'h5 && fmt[0].data_bits <= 4'h8;
    endproperty
    a_len: assert property (p_len) else $error("word length");
    property p_presc;
        !mode[0].baud_tick_en |-> ##[1:3] mode[0].baud_tick_en;
    endproperty
    a_presc: assert property (p_presc) else $error("prescale");
    property p_loop;
        mode[0].loopback && !fmt[0].break_tx |-> rx_serial_out[0] == tx_serial_in[0];
    endproperty
    a_loop: assert property (p_loop) else $error("loopback");
    property p_lsts;
        !mode[0].loopback |-> !loop_status_four[0];
    endproperty
    a_lsts: assert property (p_lsts) else $error("loop status");
    c_brk: cover property (fmt[0].break_tx);
    c_loop: cover property (mode[0].loopback);
    c_force: cover property (fmt[0].parity_forced && fmt[0].parity_en);
endmodule
bind ulmc_top ulmc_top_chk #(.NCH(NCH)) u_chk (.clk(clk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .tx_serial_in(tx_serial_in), .tx_pin(tx_pin),
    .rx_serial_out(rx_serial_out), .loop_status_four(loop_status_four), .fmt(fmt), .mode(mode));
`default_nettype wire

// [verification/ulmc_line_partner.sv]
// Serial line partner wired as an echo plug on both channels.
// Assumes the same clock; the line idles at mark during reset.
`timescale 1ns/100ps
`default_nettype none
module ulmc_line_partner (
    input wire logic clk,
    input wire logic rst,
    input wire logic [1:0] line_in,
    output logic [1:0] line_out
);
    always_ff @(posedge clk or posedge rst) line_out <= rst ? 2'h3 : line_in;
endmodule
`default_nettype wire

// [verification/uart_line_modem_control_test.sv]
// Self-checking bench for the line and modem control block.
// Assumes ulmc_top, its bound checker and the line partner model.
`timescale 1ns/100ps
`default_nettype none
module uart_line_modem_control_test;
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr, err;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
    logic [1:0] txs = 2'h3, arts = 2'h3, rxp, txp, rxo, rtsn, p5, p1, ls4, ls5;
    ulmc_pkg::ulmc_fmt_t [1:0] fmt;
    ulmc_pkg::ulmc_mode_t [1:0] mode;
    int num_errors = 0, cmp_count = 0, cyc = 0;
    always #25 clk = ~clk;
    ulmc_top dut (.clk(clk), .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .tx_serial_in(txs), .rx_pin(rxp),
        .auto_rts_level(arts), .tx_pin(txp), .rx_serial_out(rxo), .rts_n(rtsn), .pin_five_out(p5),
        .pin_one_out(p1), .loop_status_four(ls4), .loop_status_five(ls5), .fmt(fmt), .mode(mode));
    ulmc_line_partner line (.clk(clk), .rst(sys_rst), .line_in(txp), .line_out(rxp));
    task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
        cmp_count++;
        if (s !== e) begin
            num_errors++;
            $display("mismatch %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
        int n = 0;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h00_0000, d};
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        #1;
    endtask
    task automatic t_format();
        for (int i = 0; i < 4; i++) begin
            apb(1'b1, 8'h00, 8'(4 + i));
            chk("len", 8'({fmt[0].data_bits, fmt[0].stop_halves}), 8'(((5 + i) * 4) + ((i == 0) ? 3 : 0)));
        end
        apb(1'b1, 8'h00, 8'h18);
        chk("even", 8'({fmt[0].parity_en, fmt[0].parity_forced, fmt[0].parity_even}), 8'h05);
        apb(1'b1, 8'h00, 8'hA8);
        chk("f1", 8'({fmt[0].parity_val_fixed, fmt[0].divisor_access, fmt[0].stop_halves}), 8'h0E);
        apb(1'b1, 8'h00, 8'h50);
        chk("brk", 8'({txp, fmt[0].parity_en}), 8'h04);
        repeat (3) @(posedge clk);
        #1;
        chk("rxbrk", 8'(rxo), 8'h02);
        apb(1'b1, 8'h00, 8'h00);
        chk("nobrk", 8'({txp, fmt[0].divisor_access}), 8'h06);
    endtask
    task automatic t_gate();
        int n = 0;
        apb(1'b1, 8'h04, 8'hF7);
        apb(1'b0, 8'h04, 8'h00);
        chk("gated", rd[7:0], 8'h13);
        chk("loop", 8'({txp[0], rtsn[0], ls4[0], ls5[0]}), 8'h0B);
        @(posedge clk);
        txs <= 2'h2;
        @(posedge clk);
        #1;
        chk("lpbk", 8'({rxo[0], txp[0]}), 8'h01);
        @(posedge clk);
        txs <= 2'h3;
        apb(1'b1, 8'h08, 8'h10);
        apb(1'b1, 8'h04, 8'hE7);
        apb(1'b0, 8'h04, 8'h00);
        chk("open", rd[7:0], 8'hE7);
        chk("mode", 8'({mode[0].infrared, mode[0].resume_any, mode[0].trig_access, mode[1].infrared}), 8'h0E);
        repeat (8) begin
            @(posedge clk);
            #1;
            n += int'(mode[0].baud_tick_en);
        end
        #1;
        chk("presc", 8'(n), 8'h02);
    endtask
    task automatic t_pins();
        apb(1'b1, 8'h0C, 8'h06);
        apb(1'b1, 8'h10, 8'h22);
        chk("dtr", 8'({p5[0], p1[0], rtsn[0]}), 8'h01);
        apb(1'b0, 8'h38, 8'h00);
        chk("unmap", {err, rd[6:0]}, 8'h80);
    endtask
    task automatic conclude();
        $display("errors %0d comparisons %0d", num_errors, cmp_count);
        if (num_errors == 0 && cmp_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    // Ceiling well above the fewer than one hundred cycles the scenarios take.
    always @(posedge clk) begin
        cyc++;
        if (cyc == 5000) begin
            num_errors++;
            conclude();
        end
    end
    initial begin
        repeat (4) @(posedge clk);
        sys_rst <= 1'b0;
        #1;
        t_format();
        t_gate();
        t_pins();
        conclude();
    end
endmodule
`default_nettype wire
